/* File: core/status_regs_pkg.sv */
// package of the status and control word block: field positions,
// reset values and the selector codes shared by the core files.
// assumes a single core clock domain driven by the instruction decoder.
package status_regs_pkg;

  // ------------------------------------------------------------
  // field positions, status word zero
  // ------------------------------------------------------------
  localparam int unsigned SW0_AUX_PTR_LSB = 13;
  localparam int unsigned SW0_SPILL_BIT = 12;
  localparam int unsigned SW0_SAT_BIT = 11;
  localparam int unsigned SW0_ONE_BIT = 10;
  localparam int unsigned SW0_IRQ_MASK_BIT = 9;
  localparam int unsigned SW0_PAGE_LSB = 0;

  // ------------------------------------------------------------
  // field positions, status word one
  // ------------------------------------------------------------
  localparam int unsigned SW1_PTR_BUF_LSB = 13;
  localparam int unsigned SW1_RAM_MAP_BIT = 12;
  localparam int unsigned SW1_TEST_BIT = 11;
  localparam int unsigned SW1_SIGN_EXT_BIT = 10;
  localparam int unsigned SW1_CARRY_BIT = 9;
  localparam int unsigned SW1_GP_OUT_BIT = 4;
  localparam int unsigned SW1_PSM_LSB = 0;
  // reserved positions of word one, all read as one
  localparam logic [15:0] SW1_ONES_MASK = 16'h01EC;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [2:0] RST_AUX_PTR = 3'h0;
  localparam logic [2:0] RST_PTR_BUF = 3'h0;
  localparam logic RST_SPILL = 1'b0;
  localparam logic RST_SAT = 1'b0;
  localparam logic RST_IRQ_MASK = 1'b1;
  localparam logic [8:0] RST_PAGE = 9'h000;
  localparam logic RST_RAM_MAP = 1'b0;
  localparam logic RST_TEST = 1'b0;
  localparam logic RST_SIGN_EXT = 1'b1;
  localparam logic RST_CARRY = 1'b1;
  localparam logic RST_GP_OUT = 1'b1;
  localparam logic [1:0] RST_PSM = 2'h0;
  // word images right after reset, built from the field values above
  localparam logic [15:0] RST_SW0_VIEW = 16'h0600;
  localparam logic [15:0] RST_SW1_VIEW = 16'h07FC;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned WORD_W = 16;

  // product shift mode codes
  typedef enum logic [1:0] {
    PSM_NONE = 2'h0,
    PSM_LEFT1 = 2'h1,
    PSM_LEFT4 = 2'h2,
    PSM_RIGHT6 = 2'h3
  } psm_e;

  // control bits reachable by the single-bit set and clear operations
  typedef enum logic [2:0] {
    CTL_SAT,
    CTL_IRQ_MASK,
    CTL_RAM_MAP,
    CTL_SIGN_EXT,
    CTL_CARRY,
    CTL_GP_OUT,
    CTL_TEST
  } ctl_bit_e;

endpackage

/* File: core/product_scale_if.sv */
// interface carrying the product and its shift mode to the scaler.
// assumes both ends sit in the same core clock domain.
`timescale 1ns/1ps
`default_nettype none
interface product_scale_if;
  logic [31:0] product; // held product
  logic [1:0] mode; // shift mode field
  logic [31:0] scaled; // product after scaling
  modport holder (output product, output mode, input scaled);
  modport scaler (input product, input mode, output scaled);
endinterface
`default_nettype wire

/* File: core/product_scaler.sv */
// combinational product scaler between the product register and the
// arithmetic unit or write data bus. leaves the product itself untouched.
`timescale 1ns/1ps
`default_nettype none
module product_scaler
  import status_regs_pkg::*;
(
  // product and mode in, scaled value out
  product_scale_if.scaler port_p
);

  // ------------------------------------------------------------
  // shift selection
  // ------------------------------------------------------------
  always_comb begin
    case (psm_e'(port_p.mode))
      PSM_NONE: port_p.scaled = port_p.product;
      PSM_LEFT1: port_p.scaled = {port_p.product[30:0], 1'b0};
      PSM_LEFT4: port_p.scaled = {port_p.product[27:0], 4'h0};
      PSM_RIGHT6: port_p.scaled = {{6{port_p.product[31]}},
                                   port_p.product[31:6]};
      default: port_p.scaled = port_p.product;
    endcase
  end

endmodule
`default_nettype wire

/* File: core/dsp_core_status_registers.sv */
// status and control words of the core, with product register, temporary
// operand register and return stack. driven by the instruction decoder
// in the core clock domain; every input but the asynchronous reset i_rst is synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module dsp_core_status_registers
  import status_regs_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  // clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  // status load and store
  input wire logic i_load_status_op,
  input wire logic i_load_word_sel,
  input wire logic [15:0] i_load_data,
  input wire logic i_store_status_op,
  input wire logic i_store_word_sel,
  // single-bit control
  input wire logic i_set_control_bit_op,
  input wire logic i_clear_control_bit_op,
  input wire ctl_bit_e i_ctl_bit,
  // pointer, page and mode loads
  input wire logic i_load_aux_ptr_op,
  input wire logic [2:0] i_aux_ptr_value,
  input wire logic i_load_page_op,
  input wire logic [8:0] i_page_value,
  input wire logic i_load_psm_op,
  input wire logic [1:0] i_psm_value,
  input wire logic [6:0] i_instr_low7,
  // arithmetic results
  input wire logic i_alu_overflow,
  input wire logic i_spill_branch,
  input wire logic i_add_done,
  input wire logic i_add_carry,
  input wire logic i_sub_done,
  input wire logic i_sub_borrow,
  input wire logic i_shift16,
  input wire logic i_shift_done,
  input wire logic i_shift_carry,
  input wire logic i_test_done,
  input wire logic i_test_value,
  // interrupts
  input wire logic i_irq_pending,
  input wire logic i_nmi_request,
  input wire logic i_irq_acknowledge,
  input wire logic i_irq_trap_taken,
  // multiplier and temporary register
  input wire logic i_load_temp_op,
  input wire logic [15:0] i_temp_data,
  input wire logic i_mult_op,
  input wire logic i_mult_unsigned,
  input wire logic [15:0] i_mult_operand,
  // return stack
  input wire logic i_stack_push,
  input wire logic i_stack_pop,
  input wire logic [15:0] i_stack_data,
  // status views
  output logic [15:0] o_status_word_zero,
  output logic [15:0] o_status_word_one,
  output logic [15:0] o_store_data,
  output logic o_store_valid,
  // derived controls
  output logic [15:0] o_direct_address,
  output logic o_irq_accept,
  output logic o_nmi_accept,
  output logic o_general_output_pin,
  output logic o_ram_map_select,
  output logic o_sign_extend_mode,
  output logic o_saturation_mode,
  output logic [2:0] o_aux_pointer,
  // datapath values
  output logic [31:0] o_product_scaled,
  output logic [15:0] o_multiplier_operand,
  output logic [15:0] o_stack_top
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] aux_pointer; // selected aux register
    logic [2:0] aux_pointer_buffer; // previous pointer
    logic arith_spill_flag; // latched overflow
    logic saturation_mode_bit; // saturating accumulate
    logic global_irq_mask; // maskable interrupt block
    logic [8:0] direct_page_pointer; // direct page
    logic ram_map_select; // dual port ram placement
    logic test_flag; // test result
    logic sign_extend_mode; // input sign extension
    logic carry; // carry flag
    logic general_output_bit; // general output pin
    logic [1:0] product_shift_mode; // scaler mode
    logic [31:0] product_holding_reg; // product
    logic [15:0] multiplier_operand_reg; // temporary register
    logic [DEPTH-1:0][15:0] stack; // return stack, entry 0 on top
    logic [15:0] sw0_view; // registered word zero
    logic [15:0] sw1_view; // registered word one
    logic [15:0] store_data; // store result
    logic store_valid; // store result strobe
    logic [31:0] scaled; // registered scaler output
    logic [15:0] direct_address; // page and offset
    logic irq_accept; // maskable request passed
    logic nmi_accept; // nmi passed
  } state_s;

  state_s state_r; // registered state
  state_s state_nxt; // next state

  product_scale_if scale_bus (); // link to the scaler

  // ------------------------------------------------------------
  // packing helpers
  // ------------------------------------------------------------
  // word zero image from state fields
  function automatic logic [15:0] pack_sw0(input state_s s);
    logic [15:0] w;
    w = 16'h0000;
    w[SW0_AUX_PTR_LSB +: 3] = s.aux_pointer;
    w[SW0_SPILL_BIT] = s.arith_spill_flag;
    w[SW0_SAT_BIT] = s.saturation_mode_bit;
    w[SW0_ONE_BIT] = 1'b1;
    w[SW0_IRQ_MASK_BIT] = s.global_irq_mask;
    w[SW0_PAGE_LSB +: 9] = s.direct_page_pointer;
    return w;
  endfunction

  // word one image from state fields
  function automatic logic [15:0] pack_sw1(input state_s s);
    logic [15:0] w;
    w = SW1_ONES_MASK;
    w[SW1_PTR_BUF_LSB +: 3] = s.aux_pointer_buffer;
    w[SW1_RAM_MAP_BIT] = s.ram_map_select;
    w[SW1_TEST_BIT] = s.test_flag;
    w[SW1_SIGN_EXT_BIT] = s.sign_extend_mode;
    w[SW1_CARRY_BIT] = s.carry;
    w[SW1_GP_OUT_BIT] = s.general_output_bit;
    w[SW1_PSM_LSB +: 2] = s.product_shift_mode;
    return w;
  endfunction

  // ------------------------------------------------------------
  // scaler hookup
  // ------------------------------------------------------------
  assign scale_bus.product = state_r.product_holding_reg;
  assign scale_bus.mode = state_r.product_shift_mode;

  product_scaler u_scaler (
    .port_p(scale_bus)
  );

  // ------------------------------------------------------------
  // next state: implicit updates first, explicit writes last
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.store_valid = 1'b0;
    // spill flag: branch clears, a new overflow wins over it
    if (i_spill_branch) begin
      state_nxt.arith_spill_flag = 1'b0;
    end
    if (i_alu_overflow) begin
      state_nxt.arith_spill_flag = 1'b1;
    end
    // carry from arithmetic
    if (i_add_done) begin
      if (i_shift16) begin
        if (i_add_carry) begin
          state_nxt.carry = 1'b1;
        end
      end else begin
        state_nxt.carry = i_add_carry;
      end
    end
    if (i_sub_done) begin
      if (i_shift16) begin
        if (i_sub_borrow) begin
          state_nxt.carry = 1'b0;
        end
      end else begin
        state_nxt.carry = ~i_sub_borrow;
      end
    end
    if (i_shift_done) begin
      state_nxt.carry = i_shift_carry;
    end
    if (i_test_done) begin
      state_nxt.test_flag = i_test_value;
    end
    // pointer load from indirect, pointer load or modify ops
    if (i_load_aux_ptr_op) begin
      state_nxt.aux_pointer = i_aux_ptr_value;
      state_nxt.aux_pointer_buffer = state_r.aux_pointer;
    end
    if (i_load_page_op) begin
      state_nxt.direct_page_pointer = i_page_value;
    end
    if (i_load_psm_op) begin
      state_nxt.product_shift_mode = i_psm_value;
    end
    // interrupt entry masks further maskable requests
    if (i_irq_acknowledge || i_irq_trap_taken) begin
      state_nxt.global_irq_mask = 1'b1;
    end
    // load status, mask bit deliberately left alone
    if (i_load_status_op) begin
      if (!i_load_word_sel) begin
        state_nxt.aux_pointer = i_load_data[SW0_AUX_PTR_LSB +: 3];
        state_nxt.arith_spill_flag = i_load_data[SW0_SPILL_BIT];
        state_nxt.saturation_mode_bit = i_load_data[SW0_SAT_BIT];
        state_nxt.direct_page_pointer = i_load_data[SW0_PAGE_LSB +: 9];
      end else begin
        state_nxt.aux_pointer_buffer = i_load_data[SW1_PTR_BUF_LSB +: 3];
        state_nxt.aux_pointer = i_load_data[SW1_PTR_BUF_LSB +: 3];
        state_nxt.ram_map_select = i_load_data[SW1_RAM_MAP_BIT];
        state_nxt.test_flag = i_load_data[SW1_TEST_BIT];
        state_nxt.sign_extend_mode = i_load_data[SW1_SIGN_EXT_BIT];
        state_nxt.carry = i_load_data[SW1_CARRY_BIT];
        state_nxt.general_output_bit = i_load_data[SW1_GP_OUT_BIT];
        state_nxt.product_shift_mode = i_load_data[SW1_PSM_LSB +: 2];
      end
    end
    // single-bit set or clear; set taken if both are raised
    if (i_set_control_bit_op || i_clear_control_bit_op) begin
      case (i_ctl_bit)
        CTL_SAT: state_nxt.saturation_mode_bit = i_set_control_bit_op;
        CTL_IRQ_MASK: state_nxt.global_irq_mask = i_set_control_bit_op;
        CTL_RAM_MAP: state_nxt.ram_map_select = i_set_control_bit_op;
        CTL_SIGN_EXT: state_nxt.sign_extend_mode = i_set_control_bit_op;
        CTL_CARRY: state_nxt.carry = i_set_control_bit_op;
        CTL_GP_OUT: state_nxt.general_output_bit = i_set_control_bit_op;
        CTL_TEST: state_nxt.test_flag = i_set_control_bit_op;
        default: begin
          // codes without a bit leave every field, and earlier updates, alone
        end
      endcase
    end
    // temporary register and multiply
    if (i_load_temp_op) begin
      state_nxt.multiplier_operand_reg = i_temp_data;
    end
    if (i_mult_op) begin
      if (i_mult_unsigned) begin
        // both operands widened first so no high product bits are lost
        state_nxt.product_holding_reg =
          32'(state_r.multiplier_operand_reg) *
          32'(i_mult_operand);
      end else begin
        // sign-extend to full width before the product is formed
        state_nxt.product_holding_reg = 32'(
          $signed({{16{state_r.multiplier_operand_reg[15]}},
                   state_r.multiplier_operand_reg}) *
          $signed({{16{i_mult_operand[15]}}, i_mult_operand}));
      end
    end
    // return stack: push shifts down, pop shifts up keeping the bottom
    if (i_stack_push) begin
      state_nxt.stack = {state_r.stack[DEPTH-2:0], i_stack_data};
    end else if (i_stack_pop) begin
      state_nxt.stack = {state_r.stack[DEPTH-1], state_r.stack[DEPTH-1:1]};
    end
    // store status returns the words as they stand now
    if (i_store_status_op) begin
      state_nxt.store_data = i_store_word_sel ? pack_sw1(state_r)
                                              : pack_sw0(state_r);
      state_nxt.store_valid = 1'b1;
    end
    // registered views
    state_nxt.sw0_view = pack_sw0(state_nxt);
    state_nxt.sw1_view = pack_sw1(state_nxt);
    state_nxt.scaled = scale_bus.scaled;
    state_nxt.direct_address = {state_r.direct_page_pointer,
                                i_instr_low7};
    state_nxt.irq_accept = i_irq_pending & ~state_r.global_irq_mask;
    state_nxt.nmi_accept = i_nmi_request;
  end

  // ------------------------------------------------------------
  // state register, frozen while the enable is low
  // ------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= '0;
      state_r.aux_pointer <= RST_AUX_PTR;
      state_r.aux_pointer_buffer <= RST_PTR_BUF;
      state_r.arith_spill_flag <= RST_SPILL;
      state_r.saturation_mode_bit <= RST_SAT;
      state_r.global_irq_mask <= RST_IRQ_MASK;
      state_r.direct_page_pointer <= RST_PAGE;
      state_r.ram_map_select <= RST_RAM_MAP;
      state_r.test_flag <= RST_TEST;
      state_r.sign_extend_mode <= RST_SIGN_EXT;
      state_r.carry <= RST_CARRY;
      state_r.general_output_bit <= RST_GP_OUT;
      state_r.product_shift_mode <= RST_PSM;
      // views must agree with the reset field values at once
      state_r.sw0_view <= RST_SW0_VIEW;
      state_r.sw1_view <= RST_SW1_VIEW;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------
  assign o_status_word_zero = state_r.sw0_view;
  assign o_status_word_one = state_r.sw1_view;
  assign o_store_data = state_r.store_data;
  assign o_store_valid = state_r.store_valid;
  assign o_direct_address = state_r.direct_address;
  assign o_irq_accept = state_r.irq_accept;
  assign o_nmi_accept = state_r.nmi_accept;
  assign o_general_output_pin = state_r.general_output_bit;
  assign o_ram_map_select = state_r.ram_map_select;
  assign o_sign_extend_mode = state_r.sign_extend_mode;
  assign o_saturation_mode = state_r.saturation_mode_bit;
  assign o_aux_pointer = state_r.aux_pointer;
  assign o_product_scaled = state_r.scaled;
  assign o_multiplier_operand = state_r.multiplier_operand_reg;
  assign o_stack_top = state_r.stack[0];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic mask_quiet; // no other source touches the mask
  assign mask_quiet = !i_irq_acknowledge && !i_irq_trap_taken &&
    !((i_set_control_bit_op || i_clear_control_bit_op) &&
      i_ctl_bit == CTL_IRQ_MASK);

  logic carry_only_add; // only a 16-bit shift add touches carry
  assign carry_only_add = i_add_done && i_shift16 && !i_sub_done &&
    !i_shift_done && !i_load_status_op &&
    !((i_set_control_bit_op || i_clear_control_bit_op) &&
      i_ctl_bit == CTL_CARRY);

  a_reserved_ones: assert property (
    o_status_word_zero[SW0_ONE_BIT] && &(o_status_word_one | ~SW1_ONES_MASK))
    else $error("reserved status bit read as zero");

  a_lst_keeps_mask: assert property (
    i_ce && i_load_status_op && mask_quiet |=> $stable(state_r.global_irq_mask))
    else $error("status load changed the interrupt mask");

  a_ptr_to_buffer: assert property (
    i_ce && i_load_aux_ptr_op && !i_load_status_op
    |=> state_r.aux_pointer_buffer == $past(state_r.aux_pointer)
        && o_status_word_one[15:13] == $past(state_r.aux_pointer))
    else $error("old pointer not copied to buffer");

  a_buffer_to_ptr: assert property (
    i_ce && i_load_status_op && i_load_word_sel
    |=> o_aux_pointer == $past(i_load_data[15:13]))
    else $error("word one load did not copy buffer to pointer");

  a_add16_no_clear: assert property (
    i_ce && carry_only_add && !i_add_carry |=> $stable(state_r.carry))
    else $error("16-bit shift add changed carry without a carry");

  a_mask_blocks_irq: assert property (
    i_ce && state_r.global_irq_mask |=> !o_irq_accept)
    else $error("maskable interrupt passed while masked");

  a_ack_sets_mask: assert property (
    i_ce && (i_irq_acknowledge || i_irq_trap_taken) &&
    !(i_clear_control_bit_op && !i_set_control_bit_op &&
      i_ctl_bit == CTL_IRQ_MASK) |=> o_status_word_zero[9])
    else $error("interrupt entry did not set the mask");

  a_spill_latches: assert property (
    i_ce && i_alu_overflow && !i_load_status_op
    |=> o_status_word_zero[12] [*1] ##1 (o_status_word_zero[12] ||
        $past(i_spill_branch) || $past(i_load_status_op) || !$past(i_ce)))
    else $error("overflow flag not latched");

  a_page_address: assert property (
    i_ce |=> o_direct_address == {$past(state_r.direct_page_pointer),
                                  $past(i_instr_low7)})
    else $error("direct address not page over offset");

  a_right6_scale: assert property (
    i_ce && state_r.product_shift_mode == 2'h3
    |=> o_product_scaled == 32'($signed($past(state_r.product_holding_reg))
                                >>> 6))
    else $error("right-six product scaling wrong");

  c_status_load: cover property (i_ce && i_load_status_op && i_load_word_sel);
  c_trap_masked: cover property (i_ce && i_irq_trap_taken ##1 i_irq_pending);
  c_stack_push_pop: cover property (i_ce && i_stack_push ##1 i_stack_pop);
  c_signed_mult: cover property (i_ce && i_mult_op && !i_mult_unsigned);

endmodule
`default_nettype wire

/* File: tb/decoder_model.sv */
// decoder model: one op pulse a cycle, driven at the falling edge.
// assumes the block samples every input on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
  // clock
  input wire logic i_clock,
  // op pulses, selector and operand
  output logic [18:0] o_op,
  output logic [2:0] o_sel,
  output logic [15:0] o_data
);
  // quiet at time zero
  initial begin
    o_op = '0;
    o_sel = '0;
    o_data = '0;
  end
  // one op for one cycle; selector and operand stay as levels
  task automatic issue(input int op, input logic [2:0] sel,
                       input logic [15:0] data);
    @(negedge i_clock);
    o_op = 19'h00001 << op;
    o_sel = sel;
    o_data = data;
    @(negedge i_clock);
    o_op = '0;
  endtask
endmodule
`default_nettype wire

/* File: tb/dsp_core_status_registers_bench.sv */
// bench: table of status ops, then hand-written cases.
// assumes the decoder model drives all op pulses and operands.
`timescale 1ns/1ps
`default_nettype none
module dsp_core_status_registers_bench import status_regs_pkg::*;;
  typedef struct {int op; logic [2:0] sel; logic [15:0] d, w0, w1;} row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  wire logic [18:0] op;
  wire logic [2:0] sel;
  wire logic [15:0] d;
  logic [15:0] w0, w1, sd, da, mo, top;
  logic sv, acc, pin, nmi, map, sgn, sat;
  logic [2:0] aux;
  logic ce = 1'b1;
  logic [31:0] ps;
  int fails = 0;
  int comparisons = 0;
  // op, selector, operand, expected words
  row_s rows[25] = '{'{0,1,16'hE003,16'hE600,16'hE1EF},
    '{0,0,16'h0000,16'h0600,16'hE1EF}, '{4,0,16'h0005,16'hA600,16'h01EF},
    '{2,4,16'h0000,16'hA600,16'h03EF}, '{3,1,16'h0000,16'hA400,16'h03EF},
    '{5,0,16'h01FF,16'hA5FF,16'h03EF}, '{7,0,16'h0000,16'hB5FF,16'h03EF},
    '{8,0,16'h0000,16'hA5FF,16'h03EF}, '{10,1,16'h0000,16'hA5FF,16'h01EF},
    '{9,1,16'h0000,16'hA5FF,16'h03EF}, '{10,2,16'h0000,16'hA5FF,16'h03EF},
    '{6,0,16'h0002,16'hA5FF,16'h03EE}, '{13,0,16'h0000,16'hA7FF,16'h03EE},
    '{3,1,16'h0000,16'hA5FF,16'h03EE}, '{0,0,16'hFFFF,16'hFDFF,16'h03EE},
    '{2,5,16'h0000,16'hFDFF,16'h03FE}, '{0,1,16'h0000,16'h1DFF,16'h01EC},
    '{11,1,16'h0000,16'h1DFF,16'h03EC}, '{12,1,16'h0000,16'h1DFF,16'h0BEC},
    '{2,2,16'h0000,16'h1DFF,16'h1BEC}, '{2,3,16'h0000,16'h1DFF,16'h1FEC},
    '{3,0,16'h0000,16'h15FF,16'h1FEC}, '{3,4,16'h0000,16'h15FF,16'h1DEC},
    '{9,2,16'h0000,16'h15FF,16'h1DEC}, '{9,3,16'h0000,16'h15FF,16'h1FEC}};
  // -6 through each product shift mode
  logic [31:0] scaled[4] = '{32'hFFFFFFFA, 32'hFFFFFFF4, 32'hFFFFFFA0,
    32'hFFFFFFFF};
  decoder_model DEC (.i_clock(clock), .o_op(op), .o_sel(sel), .o_data(d));
  dsp_core_status_registers DUT (
    .i_clock(clock), .i_rst(rst), .i_ce(ce),
    .i_load_status_op(op[0]), .i_load_word_sel(sel[0]), .i_load_data(d),
    .i_store_status_op(op[1]), .i_store_word_sel(sel[0]),
    .i_set_control_bit_op(op[2]), .i_clear_control_bit_op(op[3]),
    .i_ctl_bit(ctl_bit_e'(sel)), .i_load_aux_ptr_op(op[4]),
    .i_aux_ptr_value(d[2:0]), .i_load_page_op(op[5]), .i_page_value(d[8:0]),
    .i_load_psm_op(op[6]), .i_psm_value(d[1:0]), .i_instr_low7(d[6:0]),
    .i_alu_overflow(op[7]), .i_spill_branch(op[8]), .i_add_done(op[9]),
    .i_add_carry(sel[0]), .i_sub_done(op[10]), .i_sub_borrow(sel[0]),
    .i_shift16(sel[1]), .i_shift_done(op[11]), .i_shift_carry(sel[0]),
    .i_test_done(op[12]), .i_test_value(sel[0]), .i_irq_pending(d[15]),
    .i_nmi_request(d[14]), .i_irq_acknowledge(op[13]),
    .i_irq_trap_taken(op[14]), .i_load_temp_op(op[15]), .i_temp_data(d),
    .i_mult_op(op[16]), .i_mult_unsigned(sel[1]), .i_mult_operand(d),
    .i_stack_push(op[17]), .i_stack_pop(op[18]), .i_stack_data(d),
    .o_status_word_zero(w0), .o_status_word_one(w1), .o_store_data(sd),
    .o_store_valid(sv), .o_direct_address(da), .o_irq_accept(acc),
    .o_nmi_accept(nmi), .o_general_output_pin(pin), .o_ram_map_select(map),
    .o_sign_extend_mode(sgn), .o_saturation_mode(sat), .o_aux_pointer(aux),
    .o_product_scaled(ps), .o_multiplier_operand(mo), .o_stack_top(top));
  // compare one result, count it
  task automatic chk(input string name, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // 20 MHz clock
  initial begin
    forever #25 clock = ~clock;
  end
  // watchdog, far beyond the hundred or so cycles used
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk("word0", 32'h0600, 32'(w0));
    chk("word1", 32'h07FC, 32'(w1));
    chk("pin", 32'h1, 32'(pin));
    foreach (rows[i]) begin
      DEC.issue(rows[i].op, rows[i].sel, rows[i].d);
      chk("word0", 32'(rows[i].w0), 32'(w0));
      chk("word1", 32'(rows[i].w1), 32'(w1));
    end
    chk("controls", 32'h60, 32'({map, sgn, sat, aux, pin}));
    ce = 1'b0;
    DEC.issue(5, 3'h0, 16'h0000);
    chk("frozen word0", 32'h15FF, 32'(w0));
    ce = 1'b1;
    DEC.issue(1, 3'h1, 16'h0000);
    chk("store data", 32'h1FEC, 32'(sd));
    chk("store valid", 32'h1, 32'(sv));
    @(negedge clock);
    chk("store valid", 32'h0, 32'(sv));
    DEC.issue(13, 3'h0, 16'h8000);
    @(negedge clock);
    chk("accept", 32'h0, 32'(acc));
    DEC.issue(3, 3'h1, 16'h8000);
    @(negedge clock);
    chk("accept", 32'h1, 32'(acc));
    chk("direct address", 32'hFF80, 32'(da));
    DEC.issue(14, 3'h0, 16'hC000);
    @(negedge clock);
    chk("accept", 32'h0, 32'(acc));
    chk("nmi", 32'h1, 32'(nmi));
    DEC.issue(15, 3'h0, 16'h0003);
    chk("operand", 32'h3, 32'(mo));
    DEC.issue(16, 3'h0, 16'hFFFE);
    for (int m = 0; m < 4; m++) begin
      DEC.issue(6, 3'h0, 16'(m));
      @(negedge clock);
      chk("scaled", scaled[m], ps);
    end
    DEC.issue(16, 3'h2, 16'hFFFE);
    DEC.issue(6, 3'h0, 16'h0000);
    @(negedge clock);
    chk("unsigned product", 32'h0002FFFA, ps);
    DEC.issue(17, 3'h0, 16'h1234);
    DEC.issue(17, 3'h0, 16'h5678);
    chk("stack top", 32'h5678, 32'(top));
    DEC.issue(18, 3'h0, 16'h0000);
    chk("stack top", 32'h1234, 32'(top));
    rst = 1'b1;
    @(negedge clock);
    chk("word1", 32'h07FC, 32'(w1));
    rst = 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
